// >>> core/rta_timer_alarm.sv
`timescale 1ns/100ps
`default_nettype none
module rta_timer_alarm #(
  parameter int unsigned MCD_LIMIT = rta_pkg::MCD_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [2:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Oscillator pins
  input wire logic osc_clk_in,
  input wire logic crystal_valid_in,
  // Alarm configuration
  input wire logic [31:0] alarm_compare_in,
  input wire logic irq_enable_in,
  input wire logic wake_enable_in,
  input wire logic irq_clear_in,
  // Oscillator controls
  output logic osc_enable_out,
  output logic agc_enable_out,
  output logic xtal_mode_out,
  output logic bias_double_out,
  // Events
  output logic alarm_irq_out,
  output logic alarm_wake_out,
  output logic osc_fail_out
);
  typedef struct packed {
    logic [31:0] hold;
    logic [31:0] count;
    logic osc_en;
    logic mcd_en;
    logic osc_fail;
    logic run;
    logic aen;
    logic autorst;
    logic set_req;
    logic cap_req;
    logic alarm_flag;
    logic irq;
    logic wake;
    logic [2:0] xosc;
    logic [7:0] rdata;
  } rta_st_t;

  rta_st_t st_r;
  rta_st_t st_nxt;
  logic [31:0] newc;
  logic ctl_wr;
  logic alarm_ev;

  rta_osc_if osc ();

  rta_osc_det #(
    .LIMIT(MCD_LIMIT)
  ) u_det (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .osc_clk_in(osc_clk_in),
    .crystal_valid_in(crystal_valid_in),
    .osc(osc)
  );

  assign osc.mcd_enable = st_r.mcd_en;

  function automatic logic [7:0] hold_byte(input logic [31:0] v,
                                           input logic [1:0] idx);
    hold_byte = v[8*idx +: 8];
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    newc = st_r.count;
    alarm_ev = 1'b0;
    ctl_wr = reg_wr_in && (reg_addr_in == rta_pkg::ADDR_CTRL);
    st_nxt.wake = 1'b0;

    // Host byte write first, so a same-cycle capture wins
    if (reg_wr_in && !reg_addr_in[2]) begin
      st_nxt.hold[8*reg_addr_in[1:0] +: 8] = reg_wdata_in;
    end

    // Oscillator-cycle work; requests finish only here
    if (osc.tick) begin
      if (st_r.set_req) begin
        newc = st_r.hold;
        st_nxt.set_req = 1'b0;
      end else if (st_r.alarm_flag && st_r.autorst) begin
        newc = rta_pkg::COUNT_RST;
      end else if (st_r.run) begin
        newc = st_r.count + 32'h0000_0001;
      end
      if (st_r.cap_req) begin
        st_nxt.hold = st_r.count;
        st_nxt.cap_req = 1'b0;
      end
      st_nxt.count = newc;
      // Only a change onto the compare value fires, so a held
      // count or a bare re-enable waits for the next pass
      alarm_ev = st_r.aen && (newc == alarm_compare_in) &&
                 (newc != st_r.count);
      st_nxt.alarm_flag = alarm_ev;
    end

    // Host control writes
    if (ctl_wr) begin
      st_nxt.osc_en = reg_wdata_in[rta_pkg::CTL_OSC_EN];
      st_nxt.mcd_en = reg_wdata_in[rta_pkg::CTL_MCD_EN];
      st_nxt.run = reg_wdata_in[rta_pkg::CTL_RUN];
      st_nxt.aen = reg_wdata_in[rta_pkg::CTL_AEN];
      st_nxt.autorst = reg_wdata_in[rta_pkg::CTL_ALARM];
      st_nxt.set_req = st_nxt.set_req |
                       reg_wdata_in[rta_pkg::CTL_SET];
      st_nxt.cap_req = st_nxt.cap_req |
                       reg_wdata_in[rta_pkg::CTL_CAP];
      if (!reg_wdata_in[rta_pkg::CTL_OSC_FAIL]) begin
        st_nxt.osc_fail = 1'b0;
      end
      if (!reg_wdata_in[rta_pkg::CTL_AEN]) begin
        st_nxt.alarm_flag = 1'b0;
      end
    end
    if (reg_wr_in && (reg_addr_in == rta_pkg::ADDR_OSC)) begin
      st_nxt.xosc = reg_wdata_in[rta_pkg::OSC_AGC:rta_pkg::OSC_BIAS2];
    end

    // Detector timeout beats a same-cycle software clear
    if (osc.timeout) begin
      st_nxt.osc_fail = 1'b1;
    end

    // Event outlives the flag; set wins over clear
    if (irq_clear_in) begin
      st_nxt.irq = 1'b0;
    end
    if (alarm_ev && irq_enable_in) begin
      st_nxt.irq = 1'b1;
    end
    st_nxt.wake = alarm_ev && wake_enable_in;

    // Read mux, one cycle latency
    case (reg_addr_in)
      rta_pkg::ADDR_HOLD0,
      rta_pkg::ADDR_HOLD1,
      rta_pkg::ADDR_HOLD2,
      rta_pkg::ADDR_HOLD3: begin
        st_nxt.rdata = hold_byte(st_r.hold, reg_addr_in[1:0]);
      end
      rta_pkg::ADDR_CTRL: begin
        st_nxt.rdata = {st_r.osc_en, st_r.mcd_en, st_r.osc_fail,
                        st_r.run, st_r.aen, st_r.alarm_flag,
                        st_r.set_req, st_r.cap_req};
      end
      rta_pkg::ADDR_OSC: begin
        // Crystal valid is raw; meaningless early after enable
        st_nxt.rdata = {st_r.xosc, osc.clk_valid, 4'h0};
      end
      default: begin
        st_nxt.rdata = rta_pkg::RDATA_RST;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.hold <= rta_pkg::HOLD_RST;
      st_r.count <= rta_pkg::COUNT_RST;
      st_r.xosc <= rta_pkg::OSC_RST;
      st_r.rdata <= rta_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign osc_enable_out = st_r.osc_en;
  assign agc_enable_out = st_r.xosc[2];
  assign xtal_mode_out = st_r.xosc[1];
  assign bias_double_out = st_r.xosc[0];
  assign alarm_irq_out = st_r.irq;
  assign alarm_wake_out = st_r.wake;
  assign osc_fail_out = st_r.osc_fail;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  run_increment_a: assert property (
    osc.tick && st_r.run && !st_r.set_req &&
    !(st_r.alarm_flag && st_r.autorst)
    |=> st_r.count == $past(st_r.count) + 32'h0000_0001)
    else $error("count did not advance on tick");

  stop_holds_a: assert property (
    (!osc.tick || (!st_r.run && !st_r.set_req &&
     !(st_r.alarm_flag && st_r.autorst)))
    |=> $stable(st_r.count))
    else $error("count moved while stopped");

  wrap_zero_a: assert property (
    osc.tick && st_r.run && !st_r.set_req &&
    !(st_r.alarm_flag && st_r.autorst) && (&st_r.count)
    |=> st_r.count == 32'h0000_0000)
    else $error("count did not wrap");

  set_load_a: assert property (
    osc.tick && st_r.set_req && !ctl_wr
    |=> (st_r.count == $past(st_r.hold)) && !st_r.set_req)
    else $error("set did not load holding value");

  capture_snap_a: assert property (
    osc.tick && st_r.cap_req && !reg_wr_in
    |=> (st_r.hold == $past(st_r.count)) && !st_r.cap_req)
    else $error("capture did not snapshot");

  req_waits_tick_a: assert property (
    st_r.cap_req && !osc.tick |=> st_r.cap_req)
    else $error("capture cleared before oscillator tick");

  alarm_match_a: assert property (
    $rose(st_r.alarm_flag)
    |-> (st_r.count == $past(alarm_compare_in)) && $past(st_r.aen))
    else $error("alarm flag without match");

  auto_clear_a: assert property (
    osc.tick && st_r.alarm_flag && st_r.autorst && !st_r.set_req
    |=> st_r.count == 32'h0000_0000)
    else $error("auto reset did not clear count");

  aen_clears_flag_a: assert property (
    ctl_wr && !reg_wdata_in[rta_pkg::CTL_AEN] |=> !st_r.alarm_flag)
    else $error("alarm flag survived disable");

  irq_latched_a: assert property (
    osc.tick && st_r.aen && irq_enable_in && alarm_ev
    |=> st_r.irq ##1 (st_r.irq || $past(irq_clear_in)))
    else $error("alarm interrupt not held");

  fail_sticky_a: assert property (
    st_r.osc_fail && !(ctl_wr && !reg_wdata_in[rta_pkg::CTL_OSC_FAIL])
    |=> st_r.osc_fail)
    else $error("fail flag dropped without clear");

  wake_pulse_a: assert property (
    alarm_ev && wake_enable_in |=> st_r.wake)
    else $error("alarm wake pulse missing");

  wake_quiet_a: assert property (
    !(alarm_ev && wake_enable_in) |=> !st_r.wake)
    else $error("wake pulse without alarm");

  irq_set_a: assert property (
    alarm_ev && irq_enable_in |=> st_r.irq)
    else $error("alarm interrupt not posted");

  flag_one_tick_a: assert property (
    st_r.alarm_flag && osc.tick |=> !st_r.alarm_flag)
    else $error("alarm flag outlived a tick");

  no_alarm_off_a: assert property (
    !st_r.aen |=> !$rose(st_r.alarm_flag))
    else $error("alarm flag rose while disabled");

  ctrl_flag_read_a: assert property (
    reg_addr_in == rta_pkg::ADDR_CTRL
    |=> reg_rdata_out[rta_pkg::CTL_ALARM] == $past(st_r.alarm_flag))
    else $error("control read lost alarm flag");

  hold_write_a: assert property (
    reg_wr_in && !reg_addr_in[2] && !(osc.tick && st_r.cap_req)
    |=> hold_byte(st_r.hold, $past(reg_addr_in[1:0])) ==
        $past(reg_wdata_in))
    else $error("holding byte write lost");

  run_write_a: assert property (
    ctl_wr |=> st_r.run == $past(reg_wdata_in[rta_pkg::CTL_RUN]))
    else $error("run bit write lost");

  osc_en_write_a: assert property (
    ctl_wr
    |=> osc_enable_out == $past(reg_wdata_in[rta_pkg::CTL_OSC_EN]))
    else $error("oscillator enable write lost");

  set_waits_tick_a: assert property (
    st_r.set_req && !osc.tick |=> st_r.set_req)
    else $error("set cleared before oscillator tick");

  mcd_off_quiet_a: assert property (
    !st_r.mcd_en |=> !osc.timeout)
    else $error("timeout with detector disabled");

  fail_on_timeout_a: assert property (
    osc.timeout |=> st_r.osc_fail)
    else $error("timeout did not set fail flag");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  alarm_seen_c: cover property ($rose(st_r.alarm_flag));
  set_done_c: cover property ($fell(st_r.set_req));
  cap_done_c: cover property ($fell(st_r.cap_req));
  fail_seen_c: cover property ($rose(st_r.osc_fail));
endmodule
`default_nettype wire

// >>> core/rta_pkg.sv
// Behaviour
// - Run bit high: count each oscillator cycle
// - Run control lives at control bit 4
// - Counter wraps to zero and keeps counting
// - Set and capture work while counter runs
// - Set bit loads holding value, self-clears
// - Capture bit snapshots counter, self-clears
// - Alarm event when count equals compare value
// - Auto reset clears count one cycle later
// - Bit 2 reads alarm flag, writes auto reset
// - Flag lasts one cycle, interrupt latched
// - Alarm drives wake-up, interrupt, or both
// - Alarm enable at bit 3 gates events
// - Clearing alarm enable clears alarm flag
// - Re-enable without new compare waits wrap
// - Bit 7 enables oscillator and bias
// - Bit 6 enables missing clock detector
// - Oscillator fail flag sticky until cleared
// - Four holding bytes at 0x00 to 0x03
// - Missing clock after 100 us stuck level
`default_nettype none
package rta_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [2:0] ADDR_HOLD0 = 3'h0;
  localparam logic [2:0] ADDR_HOLD1 = 3'h1;
  localparam logic [2:0] ADDR_HOLD2 = 3'h2;
  localparam logic [2:0] ADDR_HOLD3 = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  localparam logic [2:0] ADDR_OSC = 3'h5;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTL_OSC_EN = 7;
  localparam int CTL_MCD_EN = 6;
  localparam int CTL_OSC_FAIL = 5;
  localparam int CTL_RUN = 4;
  localparam int CTL_AEN = 3;
  localparam int CTL_ALARM = 2;
  localparam int CTL_SET = 1;
  localparam int CTL_CAP = 0;
  // ----------------------------------------
  // Oscillator control fields
  // ----------------------------------------
  localparam int OSC_AGC = 7;
  localparam int OSC_XMODE = 6;
  localparam int OSC_BIAS2 = 5;
  localparam int OSC_VALID = 4;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [2:0] OSC_RST = 3'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MCD_TIME_US = 100;
  localparam int MCD_CYCLES = MCD_TIME_US * CLK_MHZ;
  localparam int MCD_CNT_W = 14;
endpackage
`default_nettype wire

// >>> core/rta_osc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rta_osc_if;
  logic tick;
  logic timeout;
  logic clk_valid;
  logic mcd_enable;
  modport det (
    output tick,
    output timeout,
    output clk_valid,
    input mcd_enable
  );
  modport core (
    input tick,
    input timeout,
    input clk_valid,
    output mcd_enable
  );
endinterface
`default_nettype wire

// >>> core/rta_osc_det.sv
`timescale 1ns/100ps
`default_nettype none
module rta_osc_det #(
  parameter int unsigned LIMIT = rta_pkg::MCD_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Pins
  input wire logic osc_clk_in,
  input wire logic crystal_valid_in,
  // Core side
  rta_osc_if.det osc
);
  localparam int W = rta_pkg::MCD_CNT_W;
  localparam logic [W-1:0] LIM = W'(LIMIT);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic v1;
    logic v2;
    logic [W-1:0] cnt;
    logic tick;
    logic timeout;
  } rta_det_st_t;

  rta_det_st_t st_r;
  rta_det_st_t st_nxt;
  logic edge_seen;

  // ----------------------------------------
  // Synchronise, find edges, time stuck levels
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = osc_clk_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.v1 = crystal_valid_in;
    st_nxt.v2 = st_r.v1;
    edge_seen = st_r.s2 ^ st_r.s3;
    st_nxt.tick = st_r.s2 & ~st_r.s3;
    st_nxt.timeout = 1'b0;
    // One-shot: counter parks at the limit until an edge returns
    if (!osc.mcd_enable || edge_seen) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt != LIM) begin
      st_nxt.cnt = st_r.cnt + W'(1);
      st_nxt.timeout = (st_nxt.cnt == LIM);
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign osc.tick = st_r.tick;
  assign osc.timeout = st_r.timeout;
  assign osc.clk_valid = st_r.v2;

  timeout_at_limit_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    st_r.timeout |-> (st_r.cnt == LIM) && $past(osc.mcd_enable))
    else $error("timeout without full stuck interval");
endmodule
`default_nettype wire

// >>> dv/test_rta_timer_alarm.sv
`timescale 1ns/100ps
`default_nettype none
module test_rta_timer_alarm;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int unsigned LIM = 20;
  logic clk_in;
  logic sys_rst_in;
  logic [2:0] reg_addr_in;
  logic reg_wr_in;
  logic [7:0] reg_wdata_in;
  logic [7:0] reg_rdata_out;
  logic osc_clk_in;
  logic crystal_valid_in;
  logic [31:0] alarm_compare_in;
  logic irq_enable_in;
  logic wake_enable_in;
  logic irq_clear_in;
  logic osc_enable_out;
  logic agc_enable_out;
  logic xtal_mode_out;
  logic bias_double_out;
  logic alarm_irq_out;
  logic alarm_wake_out;
  logic osc_fail_out;
  int failures;
  int checks_done;
  int wakes = 0;
  logic [7:0] d;
  logic [31:0] v;
  int i;

  rta_timer_alarm #(.MCD_LIMIT(LIM)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .osc_clk_in(osc_clk_in), .crystal_valid_in(crystal_valid_in),
    .alarm_compare_in(alarm_compare_in), .irq_enable_in(irq_enable_in),
    .wake_enable_in(wake_enable_in), .irq_clear_in(irq_clear_in),
    .osc_enable_out(osc_enable_out), .agc_enable_out(agc_enable_out),
    .xtal_mode_out(xtal_mode_out), .bias_double_out(bias_double_out),
    .alarm_irq_out(alarm_irq_out), .alarm_wake_out(alarm_wake_out),
    .osc_fail_out(osc_fail_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Wake is a one-cycle pulse, so count it on every falling edge
  always @(negedge clk_in) begin
    if (alarm_wake_out === 1'b1) wakes <= wakes + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = x;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(negedge clk_in);
    reg_addr_in = a;
    @(negedge clk_in);
    x = reg_rdata_out;
  endtask

  task automatic wr32(input logic [31:0] x);
    for (int k = 0; k < 4; k++) wr(3'(k), x[8*k +: 8]);
  endtask

  task automatic rd32(output logic [31:0] x);
    logic [7:0] b;
    for (int k = 0; k < 4; k++) begin
      rd(3'(k), b);
      x[8*k +: 8] = b;
    end
  endtask

  // One oscillator period; long halves so the sync stages settle
  task automatic osc_cyc();
    @(negedge clk_in);
    osc_clk_in = 1'b1;
    repeat (6) @(negedge clk_in);
    osc_clk_in = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask

  // Poll a self-clearing request, one tick per try
  task automatic wclr(input int b);
    logic [7:0] c;
    int n;
    for (n = 0; n < 8; n++) begin
      osc_cyc();
      rd(rta_pkg::ADDR_CTRL, c);
      if (c[b] === 1'b0) break;
    end
    if (n == 8) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, c, 8'h00);
      close_out();
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    checks_done = 0;
    sys_rst_in = 1'b1;
    reg_addr_in = 3'h0;
    reg_wr_in = 1'b0;
    reg_wdata_in = 8'h00;
    osc_clk_in = 1'b0;
    crystal_valid_in = 1'b1;
    alarm_compare_in = 32'h0000_0005;
    irq_enable_in = 1'b1;
    wake_enable_in = 1'b1;
    irq_clear_in = 1'b0;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd32(v);
    chk(v, 32'h0000_0000);
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'h00);
    wr32(32'hfffffffe);
    rd32(v);
    chk(v, 32'hfffffffe);
    wr(3'h6, 8'h5a);
    rd(3'h6, d);
    chk(d, 8'h00);
    wr(rta_pkg::ADDR_OSC, 8'hff);
    rd(rta_pkg::ADDR_OSC, d);
    chk(d, 8'hf0);
    chk({agc_enable_out, xtal_mode_out, bias_double_out}, 3'h7);
    // Set, then wrap through the top of the count
    wr(rta_pkg::ADDR_CTRL, 8'h92);
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'h92);
    chk(osc_enable_out, 1'b1);
    wclr(1);
    repeat (3) osc_cyc();
    wr(rta_pkg::ADDR_CTRL, 8'h01);
    wclr(0);
    rd32(v);
    chk(v, 32'h0000_0001);
    repeat (2) osc_cyc();
    wr(rta_pkg::ADDR_CTRL, 8'h01);
    wclr(0);
    rd32(v);
    chk(v, 32'h0000_0001);
    wr(rta_pkg::ADDR_CTRL, 8'h91);
    wclr(0);
    rd32(v);
    chk(v == 32'h1 || v == 32'h2, 1'b1);
    // Alarm with irq and wake
    wr32(32'h0000_0003);
    wr(rta_pkg::ADDR_CTRL, 8'h92);
    wclr(1);
    wr(rta_pkg::ADDR_CTRL, 8'h98);
    repeat (2) osc_cyc();
    chk(wakes, 1);
    chk(alarm_irq_out, 1'b1);
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'h9c);
    // Stopped on the match, so a level compare would fire again
    wr(rta_pkg::ADDR_CTRL, 8'h80);
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'h80);
    wr(rta_pkg::ADDR_CTRL, 8'h88);
    osc_cyc();
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'h88);
    chk(wakes, 1);
    chk(alarm_irq_out, 1'b1);
    @(negedge clk_in);
    irq_clear_in = 1'b1;
    @(negedge clk_in);
    irq_clear_in = 1'b0;
    @(negedge clk_in);
    chk(alarm_irq_out, 1'b0);
    wr(rta_pkg::ADDR_CTRL, 8'h90);
    alarm_compare_in = 32'h0000_0006;
    osc_cyc();
    chk(wakes, 1);
    chk(alarm_irq_out, 1'b0);
    // Auto reset, irq only
    alarm_compare_in = 32'h0000_0005;
    wake_enable_in = 1'b0;
    wr32(32'h0000_0003);
    wr(rta_pkg::ADDR_CTRL, 8'h92);
    wclr(1);
    wr(rta_pkg::ADDR_CTRL, 8'h9c);
    repeat (4) osc_cyc();
    wr(rta_pkg::ADDR_CTRL, 8'h01);
    wclr(0);
    rd32(v);
    chk(v, 32'h0000_0001);
    chk(alarm_irq_out, 1'b1);
    chk(wakes, 1);
    // Missing clock with the oscillator held still
    wr(rta_pkg::ADDR_CTRL, 8'hc0);
    for (i = 0; i < 100; i++) begin
      @(negedge clk_in);
      if (osc_fail_out === 1'b1) break;
    end
    chk(osc_fail_out, 1'b1);
    rd(rta_pkg::ADDR_CTRL, d);
    chk(d, 8'he0);
    osc_cyc();
    chk(osc_fail_out, 1'b1);
    wr(rta_pkg::ADDR_CTRL, 8'h80);
    @(negedge clk_in);
    chk(osc_fail_out, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
